// file: verilog/pow_defs.svh
// timing counts, field positions and limits of the one-wire readout link
// assumes a single 250 MHz reference clock at both ends
`ifndef POW_DEFS_SVH
`define POW_DEFS_SVH

// ==========================================================
// clock rates
`define POW_CLK_MHZ        250
`define POW_OSC_KHZ        32
`define POW_OSC_DIV        ((`POW_CLK_MHZ * 1000) / `POW_OSC_KHZ)
`define POW_NS2CYC(ns)     ((((ns) * `POW_CLK_MHZ) + 999) / 1000)

// ==========================================================
// packet layout
`define POW_PKT_BITS       28
`define POW_VAL_BITS       14
`define POW_IR_MSB         27
`define POW_IR_LSB         14
`define POW_TMP_MSB        13
`define POW_TMP_LSB        0

// ==========================================================
// out of range limits of the infrared value
`define POW_IR_LOW         511
`define POW_IR_HIGH        (16384 - 511)

// ==========================================================
// device timing in oscillator ticks
`define POW_SAMPLE_PERIOD_US      14600
`define POW_SMPL_TICKS     (((`POW_SAMPLE_PERIOD_US * `POW_OSC_KHZ) + 999) / 1000)
`define POW_T_DIS_MS       16
`define POW_DIS_TICKS      (`POW_T_DIS_MS * `POW_OSC_KHZ)
`define POW_T_FDET_US      75
`define POW_FDET_TICKS     ((`POW_T_FDET_US * `POW_OSC_KHZ) / 1000)
`define POW_T_ADET_US      125
`define POW_ADET_TICKS     ((`POW_T_ADET_US * `POW_OSC_KHZ) / 1000)

// ==========================================================
// host timing in reference clock cycles
`define POW_T_FORCE_NS     110000
`define POW_FORCE_CYC      `POW_NS2CYC(`POW_T_FORCE_NS)
`define POW_T_INTW_NS      75000
`define POW_INTW_CYC       `POW_NS2CYC(`POW_T_INTW_NS)
`define POW_T_ABORT_NS     145000
`define POW_ABORT_CYC      `POW_NS2CYC(`POW_T_ABORT_NS)
`define POW_T_END_NS       500
`define POW_END_CYC        `POW_NS2CYC(`POW_T_END_NS)
`define POW_T_LOW_NS       1000
`define POW_LOW_CYC        `POW_NS2CYC(`POW_T_LOW_NS)
`define POW_T_HIGH_NS      1000
`define POW_HIGH_CYC       `POW_NS2CYC(`POW_T_HIGH_NS)
`define POW_T_SETTLE_NS    20000
`define POW_SETTLE_CYC     `POW_NS2CYC(`POW_T_SETTLE_NS)
`define POW_T_PERIOD_US    10000
`define POW_PERIOD_CYC     (`POW_T_PERIOD_US * `POW_CLK_MHZ)

`endif

// file: verilog/pow_pkg.sv
// types shared by both ends of the one-wire readout link
// assumes pow_defs.svh for widths
`include "pow_defs.svh"

package pow_pkg;

  // ==========================================================
  // data types
  typedef logic [`POW_VAL_BITS-1:0] pow_sample_t;
  typedef logic [`POW_PKT_BITS-1:0] pow_packet_t;

  // ==========================================================
  // state machines
  typedef enum logic [2:0] {
    D_IDLE, D_FHIGH, D_INT, D_READY, D_BIT
  } pow_dev_state_e;

  typedef enum logic [2:0] {
    H_IDLE, H_FHIGH, H_INTWAIT, H_LOW, H_HIGH, H_SETTLE, H_END, H_ABORT
  } pow_host_state_e;

endpackage

// file: verilog/pow_if.sv
// single data line between host and sensor ends
// host drive wins over the sensor; an undriven line reads low
`timescale 1ns/100ps

interface pow_if;
  logic host_out;
  logic host_oe_n;
  logic dev_out;
  logic dev_oe_n;
  logic line;

  // ==========================================================
  // wire resolution
  assign line = !host_oe_n ? host_out : (!dev_oe_n ? dev_out : 1'b0);

  modport host (input line, output host_out, output host_oe_n);
  modport dev  (input line, output dev_out, output dev_oe_n);
endinterface

// file: verilog/pow_tick.sv
// divider giving a one-cycle enable pulse every DIV clocks
// assumes a synchronous active high reset
`timescale 1ns/100ps
`include "pow_defs.svh"

module pow_tick #(
  parameter int DIV = `POW_OSC_DIV
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // enable out
  output logic      tick
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        tick_nxt;

  // ==========================================================
  // divider
  always_comb begin
    tick_nxt = 1'b0;
    cnt_nxt  = cnt_r + 16'h0001;
    if (cnt_r == 16'(DIV - 1)) begin
      cnt_nxt  = 16'h0000;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_r <= 16'h0000;
      tick  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick  <= tick_nxt;
    end
  end
endmodule

// file: verilog/pow_device.sv
// sensor end of the one-wire readout link
// assumes the line is synchronous to ref_clk; timeouts run on a 32 kHz enable
`timescale 1ns/100ps
`include "pow_defs.svh"

module pow_device
  import pow_pkg::*;
#(
  parameter int OSC_DIV = `POW_OSC_DIV
) (
  // clock and reset
  input  wire logic  ref_clk,
  input  wire logic  reset,
  // link
  pow_if.dev         link,
  // sensor values
  input  pow_sample_t ir_value,
  input  pow_sample_t temp_value,
  // status
  output logic       discharge,
  output logic       int_mode
);
  pow_dev_state_e st_r, st_nxt;
  pow_packet_t    shift_r, shift_nxt;
  logic [4:0]     bit_r, bit_nxt;
  logic [9:0]     idle_r, idle_nxt;
  logic [2:0]     hi_r, hi_nxt;
  logic [2:0]     lo_r, lo_nxt;
  logic [9:0]     dis_r, dis_nxt;
  logic           line_d_r, out_r, out_nxt, oe_n_r, oe_n_nxt, mode_r, mode_nxt;
  logic           tick, rise;

  pow_tick #(.DIV(OSC_DIV)) pow_tick_inst (
    .ref_clk (ref_clk),
    .reset   (reset),
    .tick    (tick)
  );

  assign rise          = link.line & ~line_d_r;
  assign link.dev_out  = out_r;
  assign link.dev_oe_n = oe_n_r;
  assign int_mode      = mode_r;

  // ==========================================================
  // next state
  always_comb begin
    st_nxt    = st_r;
    shift_nxt = shift_r;
    bit_nxt   = bit_r;
    idle_nxt  = idle_r;
    hi_nxt    = hi_r;
    lo_nxt    = lo_r;
    out_nxt   = out_r;
    oe_n_nxt  = oe_n_r;
    mode_nxt  = mode_r;
    dis_nxt   = dis_r;
    if (dis_r != 10'h000) begin
      if (tick) dis_nxt = dis_r - 10'h001;
    end else if (ir_value < 14'(`POW_IR_LOW) || ir_value > 14'(`POW_IR_HIGH)) begin
      dis_nxt = 10'(`POW_DIS_TICKS);
    end
    if (tick && idle_r != 10'(`POW_SMPL_TICKS)) idle_nxt = idle_r + 10'h001;
    // abort watch: low time in ticks, cleared by any high level
    if (link.line) lo_nxt = 3'h0;
    else if (tick && lo_r != 3'h7) lo_nxt = lo_r + 3'h1;
    unique case (st_r)
      D_IDLE: begin
        // rising edge starts a forced readout
        if (rise) begin
          shift_nxt = {ir_value, temp_value};
          hi_nxt    = 3'h0;
          idle_nxt  = 10'h000;
          st_nxt    = D_FHIGH;
        end else if (idle_r == 10'(`POW_SMPL_TICKS)) begin
          // raise interrupt when host stays silent
          shift_nxt = {ir_value, temp_value};
          idle_nxt  = 10'h000;
          out_nxt   = 1'b1;
          oe_n_nxt  = 1'b0;
          mode_nxt  = 1'b1;
          st_nxt    = D_INT;
        end
      end
      D_FHIGH: begin
        if (tick && hi_r != 3'h7) hi_nxt = hi_r + 3'h1;
        if (!link.line) begin
          // short high pulses are noise, not a start
          if (hi_r >= 3'(`POW_FDET_TICKS)) begin
            mode_nxt = 1'b0;
            st_nxt   = D_READY;
          end else begin
            st_nxt = D_IDLE;
          end
        end
      end
      D_INT: begin
        // host pulling low answers the interrupt
        if (!link.line) begin
          oe_n_nxt = 1'b1;
          st_nxt   = D_READY;
        end else if (idle_r == 10'(`POW_SMPL_TICKS)) begin
          oe_n_nxt = 1'b1;
          st_nxt   = D_IDLE;
        end
      end
      D_READY, D_BIT: begin
        if (lo_r >= 3'(`POW_ADET_TICKS)) begin
          oe_n_nxt = 1'b1;
          st_nxt   = D_IDLE;
        end else if (st_r == D_BIT && bit_r == 5'(`POW_PKT_BITS)) begin
          // a last 0 bit hides the host low, so it is held two ticks
          if (!link.line && (out_r || lo_r >= 3'h2)) begin
            oe_n_nxt = 1'b1;
            st_nxt   = D_IDLE;
          end
        end else if (rise) begin
          out_nxt   = shift_r[`POW_PKT_BITS-1];
          oe_n_nxt  = 1'b0;
          shift_nxt = {shift_r[`POW_PKT_BITS-2:0], 1'b0};
          bit_nxt   = (st_r == D_READY) ? 5'h01 : bit_r + 5'h01;
          st_nxt    = D_BIT;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r      <= D_IDLE;
      shift_r   <= '0;
      bit_r     <= 5'h00;
      idle_r    <= 10'h000;
      hi_r      <= 3'h0;
      lo_r      <= 3'h0;
      dis_r     <= 10'h000;
      line_d_r  <= 1'b0;
      out_r     <= 1'b0;
      oe_n_r    <= 1'b1;
      mode_r    <= 1'b0;
      discharge <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      shift_r   <= shift_nxt;
      bit_r     <= bit_nxt;
      idle_r    <= idle_nxt;
      hi_r      <= hi_nxt;
      lo_r      <= lo_nxt;
      dis_r     <= dis_nxt;
      line_d_r  <= link.line;
      out_r     <= out_nxt;
      oe_n_r    <= oe_n_nxt;
      mode_r    <= mode_nxt;
      discharge <= (dis_nxt != 10'h000);
    end
  end
endmodule

// file: verilog/pow_host.sv
// host end of the one-wire readout link
// assumes the line is synchronous to ref_clk and the sensor end keeps its timing
`timescale 1ns/100ps
`include "pow_defs.svh"

module pow_host
  import pow_pkg::*;
#(
  parameter int CW         = 22,
  parameter int FORCE_CYC  = `POW_FORCE_CYC,
  parameter int INTW_CYC   = `POW_INTW_CYC,
  parameter int ABORT_CYC  = `POW_ABORT_CYC,
  parameter int END_CYC    = `POW_END_CYC,
  parameter int LOW_CYC    = `POW_LOW_CYC,
  parameter int HIGH_CYC   = `POW_HIGH_CYC,
  parameter int SETTLE_CYC = `POW_SETTLE_CYC,
  parameter int PERIOD_CYC = `POW_PERIOD_CYC
) (
  // clock and reset
  input  wire logic   ref_clk,
  input  wire logic   reset,
  // link
  pow_if.host         link,
  // user requests
  input  wire logic   force_req,
  input  wire logic   auto_en,
  input  wire logic   abort_req,
  // readout results
  output pow_sample_t ir_value,
  output pow_sample_t temp_value,
  output logic        data_valid,
  output logic        from_int,
  output logic        busy
);
  pow_host_state_e st_r, st_nxt;
  logic [CW-1:0]   cnt_r, cnt_nxt;
  logic [CW-1:0]   per_r, per_nxt;
  pow_packet_t     shift_r, shift_nxt;
  logic [4:0]      bit_r, bit_nxt;
  logic            pend_r, pend_nxt;
  logic            out_r, out_nxt, oe_n_r, oe_n_nxt;
  pow_sample_t     ir_nxt, tmp_nxt;
  logic            valid_nxt, int_nxt, busy_nxt;
  logic            line_d_r, rise;

  assign rise           = link.line & ~line_d_r;
  assign link.host_out  = out_r;
  assign link.host_oe_n = oe_n_r;

  // ==========================================================
  // next state
  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    per_nxt   = per_r;
    shift_nxt = shift_r;
    bit_nxt   = bit_r;
    pend_nxt  = pend_r;
    out_nxt   = out_r;
    oe_n_nxt  = oe_n_r;
    ir_nxt    = ir_value;
    tmp_nxt   = temp_value;
    valid_nxt = 1'b0;
    int_nxt   = from_int;
    busy_nxt  = busy;
    if (cnt_r != '0) cnt_nxt = cnt_r - CW'(1);
    // equal interval auto readout; a tick during a readout waits
    if (!auto_en) begin
      per_nxt = CW'(PERIOD_CYC - 1);
    end else if (per_r == '0) begin
      per_nxt  = CW'(PERIOD_CYC - 1);
      pend_nxt = 1'b1;
    end else begin
      per_nxt = per_r - CW'(1);
    end
    unique case (st_r)
      H_IDLE: begin
        // released while idle to see interrupts
        oe_n_nxt = 1'b1;
        busy_nxt = 1'b0;
        if (rise) begin
          cnt_nxt  = CW'(INTW_CYC - 1);
          int_nxt  = 1'b1;
          busy_nxt = 1'b1;
          st_nxt   = H_INTWAIT;
        end else if (force_req || pend_r || pend_nxt) begin
          pend_nxt = 1'b0;
          out_nxt  = 1'b1;
          oe_n_nxt = 1'b0;
          cnt_nxt  = CW'(FORCE_CYC - 1);
          int_nxt  = 1'b0;
          busy_nxt = 1'b1;
          st_nxt   = H_FHIGH;
        end
      end
      H_FHIGH: begin
        if (cnt_r == '0) begin
          bit_nxt = 5'h00;
          out_nxt = 1'b0;
          cnt_nxt = CW'(LOW_CYC - 1);
          st_nxt  = H_LOW;
        end
      end
      H_INTWAIT: begin
        // line must stay high for the full wait
        if (abort_req) begin
          out_nxt  = 1'b0;
          oe_n_nxt = 1'b0;
          cnt_nxt  = CW'(ABORT_CYC - 1);
          st_nxt   = H_ABORT;
        end else if (!link.line) begin
          st_nxt = H_IDLE;
        end else if (cnt_r == '0) begin
          // answer the interrupt by pulling low
          bit_nxt  = 5'h00;
          out_nxt  = 1'b0;
          oe_n_nxt = 1'b0;
          cnt_nxt  = CW'(LOW_CYC - 1);
          st_nxt   = H_LOW;
        end
      end
      H_LOW, H_HIGH, H_SETTLE: begin
        if (abort_req) begin
          out_nxt  = 1'b0;
          oe_n_nxt = 1'b0;
          cnt_nxt  = CW'(ABORT_CYC - 1);
          st_nxt   = H_ABORT;
        end else if (cnt_r == '0) begin
          if (st_r == H_LOW) begin
            out_nxt = 1'b1;
            cnt_nxt = CW'(HIGH_CYC - 1);
            st_nxt  = H_HIGH;
          end else if (st_r == H_HIGH) begin
            // release so the sensor shows the bit
            oe_n_nxt = 1'b1;
            cnt_nxt  = CW'(SETTLE_CYC - 1);
            st_nxt   = H_SETTLE;
          end else begin
            // settle time keeps the bit under 25 us
            shift_nxt = {shift_r[`POW_PKT_BITS-2:0], link.line};
            bit_nxt   = bit_r + 5'h01;
            out_nxt   = 1'b0;
            oe_n_nxt  = 1'b0;
            if (bit_r == 5'(`POW_PKT_BITS - 1)) begin
              cnt_nxt = CW'(END_CYC - 1);
              st_nxt  = H_END;
            end else begin
              // low again before the next request
              cnt_nxt = CW'(LOW_CYC - 1);
              st_nxt  = H_LOW;
            end
          end
        end
      end
      H_END: begin
        if (cnt_r == '0) begin
          // split packet into its two values
          oe_n_nxt  = 1'b1;
          ir_nxt    = shift_r[`POW_IR_MSB:`POW_IR_LSB];
          tmp_nxt   = shift_r[`POW_TMP_MSB:`POW_TMP_LSB];
          valid_nxt = 1'b1;
          st_nxt    = H_IDLE;
        end
      end
      H_ABORT: begin
        if (cnt_r == '0) begin
          oe_n_nxt = 1'b1;
          st_nxt   = H_IDLE;
        end
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r       <= H_IDLE;
      cnt_r      <= '0;
      per_r      <= '0;
      shift_r    <= '0;
      bit_r      <= 5'h00;
      pend_r     <= 1'b0;
      out_r      <= 1'b0;
      oe_n_r     <= 1'b1;
      ir_value   <= '0;
      temp_value <= '0;
      data_valid <= 1'b0;
      from_int   <= 1'b0;
      busy       <= 1'b0;
      line_d_r   <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      cnt_r      <= cnt_nxt;
      per_r      <= per_nxt;
      shift_r    <= shift_nxt;
      bit_r      <= bit_nxt;
      pend_r     <= pend_nxt;
      out_r      <= out_nxt;
      oe_n_r     <= oe_n_nxt;
      ir_value   <= ir_nxt;
      temp_value <= tmp_nxt;
      data_valid <= valid_nxt;
      from_int   <= int_nxt;
      busy       <= busy_nxt;
      line_d_r   <= link.line;
    end
  end
endmodule

// file: verif/pow_link_asserts.sv
// concurrent checks on the single line between host and sensor ends
// assumes one clock, sync active high reset, sim counts as given to the ends
`timescale 1ns/100ps

module pow_link_asserts #(
  parameter int FORCE_CYC = 600,
  parameter int INTW_CYC  = 400,
  parameter int END_CYC   = 125,
  parameter int OSC_DIV   = 100
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // line signals
  input wire logic host_out,
  input wire logic host_oe_n,
  input wire logic dev_out,
  input wire logic dev_oe_n,
  input wire logic line
);
  // ==========================================================
  // helper counters
  // 25 us low limit at 250 MHz
  localparam int LOW_MAX = 6250;

  logic        hd;
  logic        ld;
  logic [15:0] hi_cnt_r;
  logic [15:0] hi_cnt_nxt;
  logic [15:0] lo_cnt_r;
  logic [15:0] lo_cnt_nxt;
  logic [15:0] rh_cnt_r;
  logic [15:0] rh_cnt_nxt;
  logic        fs_r;
  logic        fs_nxt;
  logic        int_r;
  logic        int_nxt;
  logic        rel_r;
  logic        line_r;

  always_comb begin
    hd         = !host_oe_n && host_out;
    ld         = !host_oe_n && !host_out;
    hi_cnt_nxt = hd ? hi_cnt_r + 16'h0001 : 16'h0000;
    lo_cnt_nxt = ld ? lo_cnt_r + 16'h0001 : 16'h0000;
    rh_cnt_nxt = (host_oe_n && line) ? rh_cnt_r + 16'h0001 : 16'h0000;
    // high drive straight out of release can only be a forced start
    fs_nxt     = hd && ((hi_cnt_r == 16'h0000) ? rel_r : fs_r);
    // a rise while the host listens is the sensor's interrupt
    int_nxt    = host_oe_n && line && (int_r || !line_r);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hi_cnt_r <= 16'h0000;
      lo_cnt_r <= 16'h0000;
      rh_cnt_r <= 16'h0000;
      fs_r     <= 1'b0;
      int_r    <= 1'b0;
      rel_r    <= 1'b1;
      line_r   <= 1'b0;
    end else begin
      hi_cnt_r <= hi_cnt_nxt;
      lo_cnt_r <= lo_cnt_nxt;
      rh_cnt_r <= rh_cnt_nxt;
      fs_r     <= fs_nxt;
      int_r    <= int_nxt;
      rel_r    <= host_oe_n;
      line_r   <= line;
    end
  end

  // ==========================================================
  // assertions
  line_release_a: assert property (@(posedge ref_clk)
    reset |=> host_oe_n && dev_oe_n) else $error("line not released after reset");
  start_high_a: assert property (@(posedge ref_clk) disable iff (reset)
    fs_r && !hd |-> hi_cnt_r >= FORCE_CYC) else $error("forced start high too short");
  bit_pulse_a: assert property (@(posedge ref_clk) disable iff (reset)
    !fs_r && hi_cnt_r != 16'h0000 && !hd |-> hi_cnt_r >= 50 && hi_cnt_r <= 500)
    else $error("bit clock high time out of range");
  low_limit_a: assert property (@(posedge ref_clk) disable iff (reset)
    ld |-> lo_cnt_r < LOW_MAX) else $error("line held low too long");
  end_low_a: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(host_oe_n) && !$past(host_out) |-> lo_cnt_r >= END_CYC) else $error("final low too short");
  bit_answer_a: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(host_oe_n) && $past(host_out) |-> !dev_oe_n [*8]) else $error("sensor not driving bit");
  int_wait_a: assert property (@(posedge ref_clk) disable iff (reset)
    int_r && !host_oe_n |-> rh_cnt_r >= INTW_CYC) else $error("host answered interrupt too early");
  abort_drop_a: assert property (@(posedge ref_clk) disable iff (reset)
    lo_cnt_r > 6 * OSC_DIV |-> dev_oe_n) else $error("sensor still driving after abort");
endmodule

// file: verif/pir_one_wire_readout_tb_top.sv
// testbench joining host and sensor ends over one line
// assumes shortened sim counts: osc divider 100, forced start 600 cycles
`timescale 1ns/100ps

module pir_one_wire_readout_tb_top;
  import pow_pkg::*;

  // ==========================================================
  // signals
  logic        ref_clk;
  logic        reset;
  logic        force_req;
  logic        auto_en;
  logic        abort_req;
  pow_sample_t ir_in;
  pow_sample_t temp_in;
  pow_sample_t ir_value;
  pow_sample_t temp_value;
  logic        data_valid;
  logic        from_int;
  logic        busy;
  logic        discharge;
  logic        int_mode;
  int          err_total = 0;
  int          tests_run = 0;
  int          dv_cnt    = 0;
  int          cyc       = 0;
  int          t_start   = 0;

  // shortened counts keep the run short; abort must outlast four sensor ticks
  localparam int SIM_OSC_DIV = 100;
  localparam int SIM_FORCE   = 600;
  localparam int SIM_INTW    = 400;
  localparam int SIM_ABORT   = 4000;
  localparam int SIM_SETTLE  = 40;
  localparam int SIM_PERIOD  = 5000;
  localparam int SIM_END     = 125;

  pow_if pow_if_inst ();

  pow_host #(.FORCE_CYC(SIM_FORCE), .INTW_CYC(SIM_INTW), .ABORT_CYC(SIM_ABORT), .SETTLE_CYC(SIM_SETTLE),
    .PERIOD_CYC(SIM_PERIOD))
    pow_host_inst (.ref_clk(ref_clk), .reset(reset), .link(pow_if_inst), .force_req(force_req),
    .auto_en(auto_en), .abort_req(abort_req), .ir_value(ir_value), .temp_value(temp_value),
    .data_valid(data_valid), .from_int(from_int), .busy(busy));

  pow_device #(.OSC_DIV(SIM_OSC_DIV)) pow_device_inst (.ref_clk(ref_clk), .reset(reset), .link(pow_if_inst),
    .ir_value(ir_in), .temp_value(temp_in), .discharge(discharge), .int_mode(int_mode));

  pow_link_asserts #(.FORCE_CYC(SIM_FORCE), .INTW_CYC(SIM_INTW), .END_CYC(SIM_END), .OSC_DIV(SIM_OSC_DIV))
    pow_link_asserts_inst (.ref_clk(ref_clk), .reset(reset), .host_out(pow_if_inst.host_out),
    .host_oe_n(pow_if_inst.host_oe_n), .dev_out(pow_if_inst.dev_out),
    .dev_oe_n(pow_if_inst.dev_oe_n), .line(pow_if_inst.line));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (data_valid === 1'b1) begin
      dv_cnt <= dv_cnt + 1;
    end
  end

  // ==========================================================
  // compare and wait helpers
  task automatic chk_val(input string name, input logic [13:0] exp, input logic [13:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_rng(input string name, input int lo, input int hi, input int got);
    tests_run++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  task automatic wait_dv(output int n);
    n = 0;
    while (data_valid !== 1'b1 && n < 20000) begin
      @(negedge ref_clk);
      n++;
    end
  endtask

  task automatic pulse_force;
    @(negedge ref_clk);
    force_req = 1'b1;
    @(negedge ref_clk);
    force_req = 1'b0;
    t_start = cyc;
  endtask

  // ==========================================================
  // scenarios
  // top in-range value; inputs change mid packet and must not leak in
  task automatic t_forced;
    int n;
    ir_in   = 14'h3E01;
    temp_in = 14'h3FFF;
    pulse_force;
    repeat (1000) @(negedge ref_clk);
    ir_in   = 14'h0800;
    temp_in = 14'h0400;
    wait_dv(n);
    chk_rng("forced readout cycles", 15845, 16300, n + 1001);
    chk_val("forced ir", 14'h3E01, ir_value);
    chk_val("forced temp", 14'h3FFF, temp_value);
    chk_val("forced from_int", 14'h0000, {13'h0000, from_int});
    chk_val("discharge in range", 14'h0000, {13'h0000, discharge});
  endtask

  // abort a few bits in, with ir one count under the low limit
  task automatic t_abort;
    int n;
    int dv0;
    ir_in = 14'h01FE;
    pulse_force;
    dv0   = dv_cnt;
    repeat (3000) @(negedge ref_clk);
    abort_req = 1'b1;
    @(negedge ref_clk);
    abort_req = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 6000) begin
      @(negedge ref_clk);
      n++;
    end
    chk_rng("abort low cycles", 3990, 4200, n);
    chk_rng("abort valid count", dv0, dv0, dv_cnt);
    chk_val("abort keeps ir", 14'h3E01, ir_value);
    chk_val("sensor released", 14'h0001, {13'h0000, pow_if_inst.dev_oe_n});
    chk_val("discharge low range", 14'h0001, {13'h0000, discharge});
  endtask

  // no forced start: sensor must raise the line itself, then a full packet
  task automatic t_int;
    int n;
    ir_in   = 14'h1555;
    temp_in = 14'h2AAA;
    n       = 0;
    while (!(pow_if_inst.line === 1'b1 && pow_if_inst.host_oe_n === 1'b1) && n < 50000) begin
      @(negedge ref_clk);
      n++;
    end
    chk_rng("interrupt delay", 46400, 47600, cyc - t_start);
    wait_dv(n);
    chk_rng("interrupt readout cycles", 15400, 16400, n);
    chk_val("int ir", 14'h1555, ir_value);
    chk_val("int temp", 14'h2AAA, temp_value);
    chk_val("int from_int", 14'h0001, {13'h0000, from_int});
    chk_val("sensor int mode", 14'h0001, {13'h0000, int_mode});
  endtask

  // periodic starts: first after one period, next one period later despite an abort
  task automatic t_auto;
    int n;
    n = 0;
    @(negedge ref_clk);
    auto_en = 1'b1;
    while (busy !== 1'b1 && n < 20000) begin
      @(negedge ref_clk);
      n++;
    end
    chk_rng("auto start cycles", SIM_PERIOD, SIM_PERIOD, n);
    chk_val("auto from_int", 14'h0000, {13'h0000, from_int});
    repeat (700) @(negedge ref_clk);
    abort_req = 1'b1;
    @(negedge ref_clk);
    abort_req = 1'b0;
    n = 701;
    while (busy !== 1'b0 && n < 20000) begin
      @(negedge ref_clk);
      n++;
    end
    while (busy !== 1'b1 && n < 20000) begin
      @(negedge ref_clk);
      n++;
    end
    chk_rng("auto interval cycles", SIM_PERIOD, SIM_PERIOD, n);
    auto_en = 1'b0;
  endtask

  // ==========================================================
  // run control
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    reset     = 1'b1;
    force_req = 1'b0;
    auto_en   = 1'b0;
    abort_req = 1'b0;
    ir_in     = 14'h1000;
    temp_in   = 14'h1000;
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    @(negedge ref_clk);
    t_forced;
    t_abort;
    t_int;
    t_auto;
    test_done;
  end

  // scenarios need about 90000 cycles; cut off at 110000
  initial begin
    #440000;
    err_total++;
    test_done;
  end
endmodule
